// File: verilog/mdt_pkg.sv
// Constants and types for the instruction decode and timing block
package mdt_pkg;

   // Stretch field of the clock control register
   localparam logic [2:0] STRETCH_RST   = 3'h1;
   localparam logic [7:0] CKCON_ADDR    = 8'h8E;

   // Variable external move cycle figures: base plus stretch
   localparam logic [3:0] EXTERNAL_DATA_MOVE_RD_BASE  = 4'h3;
   localparam logic [3:0] EXTERNAL_DATA_MOVE_WR_BASE  = 4'h4;

   // Program branch cycle count, not characterised in this block
   localparam logic [3:0] CYC_BRANCH    = 4'h4;

   // Register file layout in lower internal RAM
   localparam logic [2:0] WREG_PAGE     = 3'h0;
   localparam logic [3:0] BIT_AREA_BASE = 4'h2;

   // Values driven after reset
   localparam logic [7:0]  BYTE_RST     = 8'h00;
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [3:0]  CYC_RST      = 4'h0;
   localparam logic [1:0]  LEN_RST      = 2'h1;

   // Length in bytes and execution cycles of one opcode
   typedef struct packed {
      logic [1:0] len;
      logic [3:0] cyc;
   } mdt_tim_t;

   // How the branch target of the current instruction is formed
   typedef enum logic [1:0] {
      TK_NONE = 2'h0,
      TK_PAGE = 2'h1,
      TK_LONG = 2'h2,
      TK_REL  = 2'h3
   } mdt_tkind_t;

   // Timer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_RUN  = 2'h2
   } mdt_tst_t;

endpackage

// File: verilog/mdt_tmr_if.sv
// Link between the decoder and its cycle timer
`timescale 1ns/100ps
`default_nettype none
interface mdt_tmr_if;
   logic       load;
   logic [3:0] cycles;
   logic       busy;
   logic       last;

   modport ctrl (output load, output cycles, input busy, input last);
   modport tmr  (input load, input cycles, output busy, output last);
endinterface
`default_nettype wire

// File: verilog/mdt_cycle_timer.sv
// Down counter that holds an instruction busy for its cycle count
`timescale 1ns/100ps
`default_nettype none
module mdt_cycle_timer #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic CLK,
   input  wire logic SYS_RST,
   // Decoder side
   mdt_tmr_if.tmr    tif
);
   typedef struct packed {
      mdt_pkg::mdt_tst_t st;
      logic [W-1:0]      cnt;
   } mdt_tmr_st_t;

   mdt_tmr_st_t st_ff;
   mdt_tmr_st_t nxt_st;

   // Reload on the last cycle lets instructions follow back to back
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff.st)
         mdt_pkg::ST_IDLE:
         begin
            if (tif.load)
            begin
               nxt_st.st  = mdt_pkg::ST_RUN;
               nxt_st.cnt = tif.cycles[W-1:0];
            end
         end
         mdt_pkg::ST_RUN:
         begin
            if (tif.load)
               nxt_st.cnt = tif.cycles[W-1:0];
            else if (st_ff.cnt == W'(1))
               nxt_st.st = mdt_pkg::ST_IDLE;
            else
               nxt_st.cnt = st_ff.cnt - W'(1);
         end
         default: nxt_st.st = mdt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         st_ff <= '{mdt_pkg::ST_IDLE, '0};
      else
         st_ff <= nxt_st;
   end

   assign tif.busy = (st_ff.st == mdt_pkg::ST_RUN);
   assign tif.last = tif.busy && (st_ff.cnt == W'(1));

   AST_TMR_COUNT: assert property (@(posedge CLK) disable iff (SYS_RST)
      tif.load && tif.cycles == 4'h2 |=> !tif.last ##1 tif.last)
      else $error("timer did not end after two cycles");
endmodule
`default_nettype wire

// File: verilog/mdt_decode.sv
// Instruction decode, operand addressing and execution timing
`timescale 1ns/100ps
`default_nettype none
module mdt_decode (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // Instruction from program memory
   input  wire logic        INSTR_VALID,
   input  wire logic [7:0]  INSTR_OPCODE,
   input  wire logic [7:0]  INSTR_BYTE2,
   input  wire logic [7:0]  INSTR_BYTE3,
   input  wire logic [15:0] INSTR_PC,
   input  wire logic [1:0]  REG_BANK,
   output logic             INSTR_READY,
   // Execution timing
   output logic             EXEC_BUSY,
   output logic             EXEC_DONE,
   output logic [1:0]       INSTR_LEN,
   output logic [3:0]       INSTR_CYCLES,
   // Branch target
   output logic [15:0]      NEXT_PC,
   output logic [15:0]      TARGET_ADDR,
   output logic [1:0]       TARGET_KIND,
   // Operand addressing
   output logic [7:0]       WREG_ADDR,
   output logic [7:0]       PTR_ADDR,
   output logic [7:0]       DIRECT_ADDR,
   output logic             DIRECT_IS_SFR,
   output logic [7:0]       BIT_BYTE_ADDR,
   output logic [2:0]       BIT_INDEX,
   output logic [7:0]       IMM8,
   output logic [15:0]      IMM16,
   output logic             EXT_MOVE_RD,
   output logic             EXT_MOVE_WR,
   output logic [2:0]       STRETCH,
   // Special function register access
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic        SFR_RD,
   input  wire logic        SFR_WR,
   input  wire logic [7:0]  SFR_WDATA,
   input  wire logic [7:0]  INT_SFR_RDATA,
   input  wire logic [7:0]  EXT_SFR_RDATA,
   output logic [7:0]       SFR_RDATA,
   output logic             EXT_SFR_WE,
   output logic [7:0]       EXT_SFR_ADDR,
   output logic [7:0]       EXT_SFR_WDATA
);
   typedef struct packed {
      logic [2:0]  stretch;
      logic [1:0]  len;
      logic [3:0]  cyc;
      logic [15:0] next_pc;
      logic [15:0] target;
      logic [1:0]  tkind;
      logic [7:0]  wreg;
      logic [7:0]  ptr;
      logic [7:0]  dir;
      logic [7:0]  bbyte;
      logic [2:0]  bidx;
      logic [7:0]  imm8;
      logic [15:0] imm16;
      logic        xrd;
      logic        xwr;
      logic [7:0]  rdata;
      logic        xwe;
      logic [7:0]  xaddr;
      logic [7:0]  xwdata;
   } mdt_st_t;

   mdt_st_t st_ff;
   mdt_st_t nxt_st;
   logic    take;
   mdt_pkg::mdt_tim_t tim;

   mdt_tmr_if tif ();

   // Addresses decoded by the core itself; unlisted ones go off-core
   function automatic logic sfr_internal(input logic [7:0] a);
      case (a)
         8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87,
         8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E,
         8'h90, 8'h92, 8'h98, 8'h99, 8'hA0, 8'hA8, 8'hA9,
         8'hB0, 8'hB8, 8'hB9, 8'hD0, 8'hE0, 8'hF0: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Length and cycle count per opcode
   function automatic mdt_pkg::mdt_tim_t op_timing(input logic [7:0] op, input logic [2:0] st);
      mdt_pkg::mdt_tim_t t;
      logic [3:0] lo;
      logic       ri;
      logic       rn;
      t  = '{2'h1, 4'h1};
      lo = op[3:0];
      ri = (lo[3:1] == 3'h3);
      rn = lo[3];
      if (lo == 4'h1)
         t = '{2'h2, mdt_pkg::CYC_BRANCH};
      else
      begin
         case (op[7:4])
            4'h0, 4'h1:
            begin
               if (lo == 4'h0)
                  t = op[4] ? '{2'h3, mdt_pkg::CYC_BRANCH} : '{2'h1, 4'h1};
               else if (lo == 4'h2)
                  t = '{2'h3, mdt_pkg::CYC_BRANCH};
               else if (lo == 4'h5)
                  t = op[4] ? '{2'h2, 4'h2} : '{2'h2, 4'h3};
               else if (ri)
                  t = '{2'h1, 4'h3};
               else if (rn)
                  t = op[4] ? '{2'h1, 4'h1} : '{2'h1, 4'h2};
            end
            4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6:
            begin
               if (lo == 4'h0)
                  t = (op[7:4] == 4'h9) ? '{2'h3, 4'h3} : '{(op[6] ? 2'h2 : 2'h3), mdt_pkg::CYC_BRANCH};
               else if (lo == 4'h2)
                  t = (op[7:4] == 4'h9) ? '{2'h2, 4'h3} : (op[6] ? '{2'h2, 4'h3} : '{2'h1, mdt_pkg::CYC_BRANCH});
               else if (lo == 4'h3)
                  t = (op[7:4] == 4'h9) ? '{2'h1, 4'h3} : (op[6] ? '{2'h3, 4'h4} : '{2'h1, 4'h1});
               else if (lo[3:1] == 3'h2)
                  t = '{2'h2, 4'h2};
               else if (ri)
                  t = '{2'h1, 4'h2};
               else
                  t = '{2'h1, 4'h1};
            end
            4'h7:
            begin
               if (lo == 4'h0)
                  t = '{2'h2, mdt_pkg::CYC_BRANCH};
               else if (lo == 4'h2)
                  t = '{2'h2, 4'h2};
               else if (lo == 4'h3)
                  t = '{2'h1, mdt_pkg::CYC_BRANCH};
               else if (lo == 4'h4)
                  t = '{2'h2, 4'h2};
               else if (lo == 4'h5)
                  t = '{2'h3, 4'h3};
               else
                  t = ri ? '{2'h2, 4'h3} : '{2'h2, 4'h2};
            end
            4'h8:
            begin
               if (lo == 4'h0)
                  t = '{2'h2, mdt_pkg::CYC_BRANCH};
               else if (lo == 4'h2)
                  t = '{2'h2, 4'h2};
               else if (lo == 4'h3)
                  t = '{2'h1, 4'h3};
               else if (lo == 4'h4)
                  t = '{2'h1, 4'h5};
               else if (lo == 4'h5)
                  t = '{2'h3, 4'h4};
               else
                  t = ri ? '{2'h2, 4'h4} : '{2'h2, 4'h3};
            end
            4'hA:
            begin
               if (lo == 4'h0 || lo == 4'h2)
                  t = '{2'h2, 4'h2};
               else if (lo == 4'h3)
                  t = '{2'h1, 4'h3};
               else if (lo == 4'h4)
                  t = '{2'h1, 4'h5};
               else if (ri)
                  t = '{2'h2, 4'h5};
               else if (rn)
                  t = '{2'h2, 4'h4};
            end
            4'hB:
            begin
               if (lo == 4'h0)
                  t = '{2'h2, 4'h2};
               else if (lo == 4'h2)
                  t = '{2'h2, 4'h3};
               else if (lo == 4'h3)
                  t = '{2'h1, 4'h1};
               else
                  t = '{2'h3, mdt_pkg::CYC_BRANCH};
            end
            4'hC, 4'hD:
            begin
               if (lo == 4'h0)
                  t = op[4] ? '{2'h2, 4'h3} : '{2'h2, 4'h4};
               else if (lo == 4'h2)
                  t = '{2'h2, 4'h3};
               else if (lo == 4'h5)
                  t = op[4] ? '{2'h3, mdt_pkg::CYC_BRANCH} : '{2'h2, 4'h3};
               else if (ri)
                  t = '{2'h1, 4'h3};
               else if (rn)
                  t = op[4] ? '{2'h2, mdt_pkg::CYC_BRANCH} : '{2'h1, 4'h2};
            end
            4'hE, 4'hF:
            begin
               if (lo == 4'h0 || lo[3:1] == 3'h1)
                  t.cyc = (op[4] ? mdt_pkg::EXTERNAL_DATA_MOVE_WR_BASE : mdt_pkg::EXTERNAL_DATA_MOVE_RD_BASE) + {1'b0, st};
               else if (lo == 4'h5)
                  t = op[4] ? '{2'h2, 4'h3} : '{2'h2, 4'h2};
               else if (ri)
                  t = op[4] ? '{2'h1, 4'h3} : '{2'h1, 4'h2};
               else if (rn)
                  t = op[4] ? '{2'h1, 4'h2} : '{2'h1, 4'h1};
            end
            default: t = '{2'h1, 4'h1};
         endcase
      end
      // accumulator one-cycle forms fall to the default
      return t;
   endfunction

   // no new instruction until the current one ends
   assign take        = INSTR_VALID && INSTR_READY;
   assign INSTR_READY = !tif.busy || tif.last;
   assign tif.load    = take;
   assign tim         = op_timing(INSTR_OPCODE, st_ff.stretch);
   assign tif.cycles  = tim.cyc;

   mdt_cycle_timer #(.W(4)) u_tmr (
      .CLK     (CLK),
      .SYS_RST (SYS_RST),
      .tif     (tif)
   );

   // Decode captured at the take edge, SPECIAL_FUNCTION_REGISTER path every cycle
   always_comb
   begin
      mdt_pkg::mdt_tim_t tm;
      logic [15:0] npc;
      logic [7:0]  rel;
      logic [7:0]  op;
      tm  = tim;
      op  = INSTR_OPCODE;
      npc = INSTR_PC + {14'h0, tm.len};
      rel = (tm.len == 2'h3) ? INSTR_BYTE3 : INSTR_BYTE2;
      nxt_st = st_ff;
      if (take)
      begin
         nxt_st.len     = tm.len;
         nxt_st.cyc     = tm.cyc;
         nxt_st.next_pc = npc;
         nxt_st.tkind   = mdt_pkg::TK_NONE;
         nxt_st.target  = npc;
         if (op[3:0] == 4'h1)
         begin
            nxt_st.tkind  = mdt_pkg::TK_PAGE;
            nxt_st.target = {npc[15:11], op[7:5], INSTR_BYTE2};
         end
         else if (op == 8'h02 || op == 8'h12)
         begin
            nxt_st.tkind  = mdt_pkg::TK_LONG;
            nxt_st.target = {INSTR_BYTE2, INSTR_BYTE3};
         end
         else if ((op[3:0] == 4'h0 && op[7:4] <= 4'h8 && op != 8'h00) || op[7:4] == 4'hB && op[3:2] != 2'h0
                  || op == 8'hD5 || op[7:3] == 5'h1B)
         begin
            nxt_st.tkind  = mdt_pkg::TK_REL;
            nxt_st.target = npc + {{8{rel[7]}}, rel};
         end
         nxt_st.ptr   = {mdt_pkg::WREG_PAGE, REG_BANK, 2'h0, op[0]};
         nxt_st.wreg  = {mdt_pkg::WREG_PAGE, REG_BANK, op[2:0]};
         nxt_st.dir   = INSTR_BYTE2;
         nxt_st.bbyte = INSTR_BYTE2[7] ? {INSTR_BYTE2[7:3], 3'h0} : {mdt_pkg::BIT_AREA_BASE, INSTR_BYTE2[6:3]};
         nxt_st.bidx  = INSTR_BYTE2[2:0];
         // immediate byte follows a direct address when present
         nxt_st.imm8  = (tm.len == 2'h3) ? INSTR_BYTE3 : INSTR_BYTE2;
         nxt_st.imm16 = {INSTR_BYTE2, INSTR_BYTE3};
         nxt_st.xrd   = (op[7:4] == 4'hE) && (op[3:0] == 4'h0 || op[3:1] == 3'h1);
         nxt_st.xwr   = (op[7:4] == 4'hF) && (op[3:0] == 4'h0 || op[3:1] == 3'h1);
      end
      // inside copy wins on a shared address
      if (SFR_RD)
      begin
         if (SFR_ADDR == mdt_pkg::CKCON_ADDR)
            nxt_st.rdata = {5'h00, st_ff.stretch};
         else
            nxt_st.rdata = sfr_internal(SFR_ADDR) ? INT_SFR_RDATA : EXT_SFR_RDATA;
      end
      nxt_st.xwe = SFR_WR;
      if (SFR_WR)
      begin
         nxt_st.xaddr  = SFR_ADDR;
         nxt_st.xwdata = SFR_WDATA;
         if (SFR_ADDR == mdt_pkg::CKCON_ADDR)
            nxt_st.stretch = SFR_WDATA[2:0];
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         st_ff <= '{mdt_pkg::STRETCH_RST, mdt_pkg::LEN_RST, mdt_pkg::CYC_RST, mdt_pkg::WORD_RST,
                    mdt_pkg::WORD_RST, mdt_pkg::TK_NONE, mdt_pkg::BYTE_RST, mdt_pkg::BYTE_RST,
                    mdt_pkg::BYTE_RST, mdt_pkg::BYTE_RST, 3'h0, mdt_pkg::BYTE_RST, mdt_pkg::WORD_RST,
                    1'b0, 1'b0, mdt_pkg::BYTE_RST, 1'b0, mdt_pkg::BYTE_RST, mdt_pkg::BYTE_RST};
      else
         st_ff <= nxt_st;
   end

   // Output drive
   assign EXEC_BUSY     = tif.busy;
   assign EXEC_DONE     = tif.last;
   assign INSTR_LEN     = st_ff.len;
   assign INSTR_CYCLES  = st_ff.cyc;
   assign NEXT_PC       = st_ff.next_pc;
   assign TARGET_ADDR   = st_ff.target;
   assign TARGET_KIND   = st_ff.tkind;
   assign WREG_ADDR     = st_ff.wreg;
   assign PTR_ADDR      = st_ff.ptr;
   assign DIRECT_ADDR   = st_ff.dir;
   assign DIRECT_IS_SFR = st_ff.dir[7];
   assign BIT_BYTE_ADDR = st_ff.bbyte;
   assign BIT_INDEX     = st_ff.bidx;
   assign IMM8          = st_ff.imm8;
   assign IMM16         = st_ff.imm16;
   assign EXT_MOVE_RD   = st_ff.xrd;
   assign EXT_MOVE_WR   = st_ff.xwr;
   assign STRETCH       = st_ff.stretch;
   assign SFR_RDATA     = st_ff.rdata;
   assign EXT_SFR_WE    = st_ff.xwe;
   assign EXT_SFR_ADDR  = st_ff.xaddr;
   assign EXT_SFR_WDATA = st_ff.xwdata;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence seq_take(logic [7:0] o);
      take && INSTR_OPCODE == o;
   endsequence

   AST_RD_INSIDE: assert property (
      SFR_RD && sfr_internal(SFR_ADDR) && SFR_ADDR != mdt_pkg::CKCON_ADDR |=> SFR_RDATA == $past(INT_SFR_RDATA))
      else $error("shared register read did not return inside copy");
   AST_WR_OUTSIDE: assert property (
      SFR_WR |=> EXT_SFR_WE && EXT_SFR_WDATA == $past(SFR_WDATA) && EXT_SFR_ADDR == $past(SFR_ADDR))
      else $error("register write not passed off-core");
   AST_LONG_TGT: assert property (
      seq_take(8'h02) |=> TARGET_ADDR == {$past(INSTR_BYTE2), $past(INSTR_BYTE3)} && TARGET_KIND == 2'h2)
      else $error("long target wrong");
   AST_PAGE_TGT: assert property (
      take && INSTR_OPCODE[3:0] == 4'h1 |=> TARGET_ADDR[15:11] == NEXT_PC[15:11] && TARGET_ADDR[7:0] == $past(INSTR_BYTE2))
      else $error("page target left its page");
   AST_REL_TGT: assert property (
      seq_take(8'h80) |=> TARGET_ADDR == $past(INSTR_PC) + 16'h0002 + {{8{$past(INSTR_BYTE2[7])}}, $past(INSTR_BYTE2)})
      else $error("relative target wrong");
   AST_PTR_BANK: assert property (
      take && INSTR_OPCODE[7:1] == 7'h73 |=> PTR_ADDR == {3'h0, $past(REG_BANK), 2'h0, $past(INSTR_OPCODE[0])})
      else $error("pointer register not in current bank");
   AST_ADD_REG: assert property (
      take && INSTR_OPCODE[7:3] == 5'h05 |=> INSTR_CYCLES == 4'h1 ##0 EXEC_DONE)
      else $error("register add not one cycle");
   AST_EXTERNAL_DATA_MOVE_RD: assert property (
      seq_take(8'hE0) |=> INSTR_CYCLES == 4'h3 + {1'b0, STRETCH} && EXT_MOVE_RD)
      else $error("external read length wrong");
   AST_EXTERNAL_DATA_MOVE_WR: assert property (
      seq_take(8'hF0) |=> INSTR_CYCLES == 4'h4 + {1'b0, STRETCH} && EXT_MOVE_WR)
      else $error("external write length wrong");
   AST_STRETCH_RST: assert property (@(posedge CLK) disable iff (1'b0)
      SYS_RST |=> STRETCH == 3'h1)
      else $error("stretch not one after reset");
   AST_NO_OVERLAP: assert property (
      EXEC_BUSY && !EXEC_DONE |-> !INSTR_READY)
      else $error("instruction accepted while busy");
   // Ready in the first busy cycle only for one-cycle instructions
   AST_READY_LAST: assert property (
      take |=> INSTR_READY == (INSTR_CYCLES == 4'h1))
      else $error("ready high before the instruction ended");
endmodule
`default_nettype wire

// File: dv/mdt_far_model.sv
// Program memory and off-core register peripheral model
`timescale 1ns/100ps
`default_nettype none
module mdt_far_model (
   // Clock
   input  wire logic        CLK,
   // Program side
   input  wire logic [15:0] pc,
   output logic [7:0]       op,
   output logic [7:0]       b2,
   output logic [7:0]       b3,
   // Off-core register side
   input  wire logic        we,
   input  wire logic [7:0]  wa,
   input  wire logic [7:0]  wd,
   input  wire logic [7:0]  ra,
   output logic [7:0]       rd
);
   logic [7:0] mem  [65536];
   logic [7:0] regs [256];
   // Code bytes in program order, wrapping at the top
   assign op = mem[pc];
   assign b2 = mem[pc + 16'h0001];
   assign b3 = mem[pc + 16'h0002];
   // Peripheral answers from its own copy, unknown until written
   assign rd = regs[ra];
   always @(posedge CLK)
      if (we)
         regs[wa] <= wd;
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the decode and timing block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0]  op;
      logic [1:0]  len;
      logic [1:0]  kind;
      logic [3:0]  cyc;
      logic [15:0] tgt;
      logic [15:0] np;
      logic [15:0] imm;
      logic [7:0]  ptr;
   } mdt_note_t;
   // Opcode, then length, target kind and cycles packed in one byte
   localparam logic [15:0] TAB [34] = '{16'h2841, 16'h2582, 16'h2642, 16'h2482, 16'h3841, 16'h9482, 16'h0441,
      16'h0842, 16'h0583, 16'h0643, 16'h5283, 16'h53C4, 16'h63C4, 16'h0341, 16'h1341, 16'h2341, 16'h3341,
      16'h85C4, 16'h90C3, 16'h8343, 16'h9343, 16'hB341, 16'hB283, 16'h8282, 16'hA082, 16'h7282, 16'h02E4,
      16'h0194, 16'h80B4, 16'hE043, 16'h8684, 16'hE343, 16'hF044, 16'hF244};
   logic clk = 1'b0, rst = 1'b1, valid = 1'b0, sfr_rd = 1'b0, sfr_wr = 1'b0;
   logic [15:0] pc = 16'h0000, next_pc, tgt, imm16, cnt = 16'h0000;
   logic [7:0] op, b2, b3, sfr_a = 8'h00, sfr_wd = 8'h00, int_rd = 8'h00, ext_rd, ptr, sfr_q, ext_a, ext_d;
   logic [7:0] wreg, dir, bbyte, imm8;
   logic [1:0] bank = 2'h0, len, kind;
   logic [3:0] cyc;
   logic [2:0] stretch, bidx;
   logic ready, busy, done, xrd, xwr, is_sfr, ext_we;
   int failures = 0, num_checks = 0;
   mdt_note_t notes [$];
   mdt_note_t m;

   // Core clock, 100 ns period
   always #50 clk = ~clk;

   mdt_far_model pm (.CLK(clk), .pc(pc), .op(op), .b2(b2), .b3(b3), .we(ext_we), .wa(ext_a), .wd(ext_d),
      .ra(sfr_a), .rd(ext_rd));
   mdt_decode dut (.CLK(clk), .SYS_RST(rst), .INSTR_VALID(valid), .INSTR_OPCODE(op), .INSTR_BYTE2(b2),
      .INSTR_BYTE3(b3), .INSTR_PC(pc), .REG_BANK(bank), .INSTR_READY(ready), .EXEC_BUSY(busy),
      .EXEC_DONE(done), .INSTR_LEN(len), .INSTR_CYCLES(cyc), .NEXT_PC(next_pc), .TARGET_ADDR(tgt),
      .TARGET_KIND(kind), .WREG_ADDR(wreg), .PTR_ADDR(ptr), .DIRECT_ADDR(dir), .DIRECT_IS_SFR(is_sfr),
      .BIT_BYTE_ADDR(bbyte), .BIT_INDEX(bidx), .IMM8(imm8), .IMM16(imm16), .EXT_MOVE_RD(xrd),
      .EXT_MOVE_WR(xwr), .STRETCH(stretch),
      .SFR_ADDR(sfr_a), .SFR_RD(sfr_rd), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wd), .INT_SFR_RDATA(int_rd),
      .EXT_SFR_RDATA(ext_rd), .SFR_RDATA(sfr_q), .EXT_SFR_WE(ext_we), .EXT_SFR_ADDR(ext_a),
      .EXT_SFR_WDATA(ext_d));

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask

   // Bounded wait; a hang counts as a mismatch
   task automatic wait_for(input logic c);
      int k;
      k = 0;
      while (k < 40 && !(c === 1'b1 ? ready === 1'b1 : notes.size() == 0))
      begin
         @(negedge clk);
         k++;
      end
      if (k == 40)
      begin
         failures++;
         tally_and_finish();
      end
   endtask

   // Sends the whole table; random gaps, otherwise back to back
   task automatic run_tab(input logic [3:0] st);
      mdt_note_t n;
      logic [15:0] a;
      logic [7:0] x;
      logic [7:0] y;
      logic [1:0] b;
      for (int i = 0; i < 34; i++)
      begin
         a = 16'($urandom);
         x = 8'($urandom);
         y = 8'($urandom);
         b = 2'($urandom);
         n.op = TAB[i][15:8];
         {n.len, n.kind, n.cyc} = TAB[i][7:0];
         n.cyc = n.cyc + (n.op inside {8'hE0, 8'hE3, 8'hF0, 8'hF2} ? st : 4'h0);
         n.np = a + 16'(n.len);
         n.imm = {x, y};
         n.ptr = {3'h0, b, 2'h0, n.op[0]};
         n.tgt = n.kind == 2'h2 ? {x, y} : n.kind == 2'h1 ? {n.np[15:11], n.op[7:5], x} : n.np + {{8{x[7]}}, x};
         if ($urandom % 4 == 0)
         begin
            valid <= 1'b0;
            @(posedge clk);
         end
         pm.mem[a] <= n.op;
         pm.mem[a + 16'h0001] <= x;
         pm.mem[a + 16'h0002] <= y;
         pc <= a;
         bank <= b;
         valid <= 1'b1;
         @(negedge clk);
         wait_for(1'b1);
         @(posedge clk);
         notes.push_back(n);
      end
      valid <= 1'b0;
   endtask

   // One register access, judged in the following cycle
   task automatic special_function_register(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_rd <= r;
      sfr_wr <= ~r;
      sfr_a <= a;
      sfr_wd <= d;
      int_rd <= d;
      @(posedge clk);
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
      @(negedge clk);
   endtask

   // Watches completions and compares with the oldest note
   always @(negedge clk)
   begin
      if (busy === 1'b1)
         cnt = cnt + 16'h0001;
      if (done === 1'b1 && notes.size() > 0)
      begin
         m = notes.pop_front();
         chk("busy cycles", 16'(m.cyc), cnt);
         chk("cycles", 16'(m.cyc), 16'(cyc));
         chk("length", 16'(m.len), 16'(len));
         chk("next pc", m.np, next_pc);
         chk("kind", 16'(m.kind), 16'(kind));
         if (m.kind != 2'h0)
            chk("target", m.tgt, tgt);
         chk("pointer", 16'(m.ptr), 16'(ptr));
         chk("immediate", m.imm, imm16);
         chk("imm8", 16'(m.len == 2'h3 ? m.imm[7:0] : m.imm[15:8]), 16'(imm8));
         chk("reg addr", 16'({m.ptr[7:3], m.op[2:0]}), 16'(wreg));
         chk("direct", 16'({m.imm[15], m.imm[15:8]}), 16'({is_sfr, dir}));
         chk("bit byte", 16'(m.imm[15] ? {m.imm[15:11], 3'h0} : {4'h2, m.imm[14:11]}), 16'(bbyte));
         chk("bit index", 16'(m.imm[10:8]), 16'(bidx));
         chk("ext read", 16'(m.op inside {8'hE0, 8'hE3}), 16'(xrd));
         chk("ext write", 16'(m.op inside {8'hF0, 8'hF2}), 16'(xwr));
         cnt = 16'h0000;
      end
   end

   initial
   begin
      void'($urandom(32'hb0b8));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("stretch", 16'h0001, 16'(stretch));
      chk("reset busy", 16'h0000, 16'(busy));
      @(posedge clk);
      run_tab(4'h1);
      special_function_register(1'b0, 8'hC0, 8'h5A);
      chk("ext addr", 16'h00C0, 16'(ext_a));
      special_function_register(1'b0, 8'h81, 8'hA5);
      chk("ext we", 16'h0001, 16'(ext_we));
      chk("ext data", 16'h00A5, 16'(ext_d));
      special_function_register(1'b1, 8'h81, 8'h66);
      chk("shared read", 16'h0066, 16'(sfr_q));
      special_function_register(1'b1, 8'hC0, 8'h11);
      chk("off-core read", 16'h005A, 16'(sfr_q));
      // Both ends of the stretch range
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         special_function_register(1'b0, 8'h8E, s == 0 ? 8'h07 : 8'h00);
         chk("stretch", s == 0 ? 16'h0007 : 16'h0000, 16'(stretch));
         @(posedge clk);
         run_tab(s == 0 ? 4'h7 : 4'h0);
      end
      wait_for(1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
